/* rtl/cas_regs.sv */
`timescale 1ns/1ps

// Operation
// - Adapter loss pulls throttle output low while CHARGE_OPTION_WORD0 bit 15 is clear
// - Channels sequenced in fixed order
// - Converter off in low power
// - Continuous mode repeats set every second
// - One-shot trigger runs exactly one set
// - Trigger bit self-clears after one-shot
// - One conversion set lasts 10 ms
// - Range bit selects 2.04 or 3.06 V
// - Bits 7..0 enable individual channels
// - Bit 15 mirrors charge-ok indication
// - Bit 14 set after optimizer completes while charge-ok is present
// - Bit 12 shows input voltage limiting
// - Bit 11 shows input current limiting
// - Bits 10..8 fast, pre, reverse
// - Bits 7..5 faults latched until read
// - Bit 4 system overvoltage, write-zero clear
// - Bits 2..0 latched until read
module cas_regs
  import cas_pkg::*;
#(
  parameter int unsigned SET_CYC    = cas_pkg::CONV_SET_CYC,
  parameter int unsigned PERIOD_CYC = cas_pkg::CONV_PERIOD_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [15:0] CHARGE_OPTION_WORD0,
  input  wire logic        CHARGE_OK_INDICATION,
  input  wire logic        INPUT_OPTIMIZER_FINISHED,
  input  wire logic        INPUT_VOLTAGE_LIMITING,
  input  wire logic        INPUT_CURRENT_LIMITING,
  input  wire logic        FAST_CHARGE,
  input  wire logic        PRECHARGE,
  input  wire logic        REVERSE_OUTPUT,
  input  wire logic        INPUT_OVERVOLTAGE_FAULT,
  input  wire logic        BATTERY_OVERCURRENT_FAULT,
  input  wire logic        INPUT_OVERCURRENT_FAULT,
  input  wire logic        SYSTEM_OVERVOLTAGE,
  input  wire logic        LATCHOFF_FAULT,
  input  wire logic        REVERSE_OVERVOLTAGE_FAULT,
  input  wire logic        REVERSE_OVERCURRENT_FAULT,
  input  wire logic        LOW_POWER_MODE,
  input  wire logic        BATTERY_ONLY,
  output logic             LOW_POWER_EXIT_REQ,
  output logic             PROCESSOR_HOT_OUTPUT_N,
  output logic             CONVERTER_ACTIVE,
  output logic [2:0]       CONV_CHANNEL,
  output logic             CONV_CHANNEL_VALID,
  output logic             CONVERSION_RANGE_SEL,
  output logic             RESULTS_UPDATE,
  output logic             POWER_STAGE_ENABLE
);

  cas_conv_state_t state_q, state_d;
  logic [15:0]     meas_q, meas_d;
  logic [15:0]     throttle_q, throttle_d;
  logic [7:0]      fault_q, fault_d;
  logic            sysov_q, sysov_d;
  logic            opt_done_q, opt_done_d;
  logic            charge_ok_q;
  logic            hot_n_q, hot_n_d;
  logic [2:0]      ch_q, ch_d;
  logic [15:0]     rdata_q, rdata_d;
  logic            rvalid_q;
  logic            tmr_clear;
  logic            tmr_done;
  logic [31:0]     tmr_limit;
  logic            wr_meas, rd_flags;
  logic [15:0]     flags_now;

  // A set covers every channel, so each channel step gets an equal share.
  // SET_CYC should be a multiple of the channel count to keep it exact.
  localparam int unsigned STEP_CYC = SET_CYC / NUM_CH;

  function automatic logic [7:0] fault_vec(input logic [15:0] f);
    return f[7:0] & 8'hE7;
  endfunction

  assign wr_meas  = REG_WR && (REG_ADDR == ADDR_MEAS_OPT);
  assign rd_flags = REG_RD && (REG_ADDR == ADDR_STATE_FLAGS);

  always_comb begin
    flags_now               = RST_STATE_FLAGS;
    flags_now[SF_PRESENT]   = charge_ok_q;
    flags_now[SF_OPT_DONE]  = opt_done_q;
    flags_now[SF_VLIM]      = INPUT_VOLTAGE_LIMITING;
    flags_now[SF_ILIM]      = INPUT_CURRENT_LIMITING;
    flags_now[SF_FAST]      = FAST_CHARGE;
    flags_now[SF_PRE]       = PRECHARGE;
    flags_now[SF_REVERSE]   = REVERSE_OUTPUT;
    flags_now[SF_SYS_OV]    = sysov_q;
    flags_now[7:0]          = flags_now[7:0] | fault_q;
  end

  // Fault latches; a fault present in the read cycle sets its bit again.
  always_comb begin
    fault_d = rd_flags ? 8'h00 : fault_q;
    fault_d[SF_IN_OV]    = fault_d[SF_IN_OV] | INPUT_OVERVOLTAGE_FAULT;
    fault_d[SF_BAT_OC]   = fault_d[SF_BAT_OC] | BATTERY_OVERCURRENT_FAULT;
    fault_d[SF_IN_OC]    = fault_d[SF_IN_OC] | INPUT_OVERCURRENT_FAULT;
    fault_d[SF_LATCHOFF] = fault_d[SF_LATCHOFF] | LATCHOFF_FAULT;
    fault_d[SF_REV_OV]   = fault_d[SF_REV_OV] | REVERSE_OVERVOLTAGE_FAULT;
    fault_d[SF_REV_OC]   = fault_d[SF_REV_OC] | REVERSE_OVERCURRENT_FAULT;
    fault_d = fault_vec({8'h00, fault_d});
    sysov_d = sysov_q;
    if (REG_WR && (REG_ADDR == ADDR_STATE_FLAGS) && !REG_WDATA[SF_SYS_OV]
        && !SYSTEM_OVERVOLTAGE) begin
      sysov_d = 1'b0;
    end
    if (!CHARGE_OK_INDICATION) begin
      sysov_d = 1'b0;
    end
    if (SYSTEM_OVERVOLTAGE) begin
      sysov_d = 1'b1;
    end
    opt_done_d = INPUT_OPTIMIZER_FINISHED && CHARGE_OK_INDICATION;
    rdata_d = rdata_q;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_STATE_FLAGS: rdata_d = flags_now;
        ADDR_THROTTLE:    rdata_d = throttle_q;
        ADDR_MEAS_OPT:    rdata_d = meas_q;
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  // Converter sequencer.
  always_comb begin
    state_d   = state_q;
    meas_d    = meas_q;
    ch_d      = ch_q;
    tmr_clear = 1'b1;
    tmr_limit = STEP_CYC;
    if (wr_meas) begin
      meas_d = REG_WDATA & MEAS_OPT_WMASK;
    end
    unique case (state_q)
      CAS_IDLE: begin
        ch_d = 3'h0;
        if (!LOW_POWER_MODE && (meas_q[MO_MODE] || meas_q[MO_TRIGGER])) begin
          state_d = CAS_CONVERT;
        end
      end
      CAS_CONVERT: begin
        tmr_clear = 1'b0;
        if (tmr_done) begin
          ch_d = ch_q + 3'h1;
          if (ch_q == CH_LAST) begin
            if (meas_q[MO_MODE]) begin
              state_d = CAS_WAIT;
            end else begin
              state_d = CAS_IDLE;
              // A host trigger written in the closing cycle wins.
              if (!wr_meas) begin
                meas_d[MO_TRIGGER] = 1'b0;
              end
            end
          end
        end
      end
      CAS_WAIT: begin
        tmr_clear = 1'b0;
        tmr_limit = PERIOD_CYC - SET_CYC;
        if (tmr_done) begin
          state_d = meas_q[MO_MODE] ? CAS_CONVERT : CAS_IDLE;
          ch_d    = 3'h0;
        end
      end
      default: state_d = CAS_IDLE;
    endcase
    if (LOW_POWER_MODE) begin
      state_d   = CAS_IDLE;
    end
    if (!meas_q[MO_MODE] && !meas_q[MO_TRIGGER] && state_q != CAS_IDLE
        && !(state_q == CAS_CONVERT)) begin
      state_d = CAS_IDLE;
    end
  end

  cas_timer #(
    .WIDTH (32)
  ) u_timer (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .CLEAR   (tmr_clear),
    .LIMIT   (tmr_limit),
    .DONE    (tmr_done)
  );

  // Throttle profile and adapter-loss output.
  always_comb begin
    throttle_d = throttle_q;
    if (REG_WR && (REG_ADDR == ADDR_THROTTLE)) begin
      throttle_d = REG_WDATA;
    end
    hot_n_d = 1'b1;
    if (throttle_q[TP_ADAPTER_LOSS] && !CHARGE_OPTION_WORD0[CO0_ADAPTER_BIT]
        && !CHARGE_OK_INDICATION) begin
      hot_n_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q     <= CAS_IDLE;
      meas_q      <= RST_MEAS_OPT;
      throttle_q  <= RST_THROTTLE;
      fault_q     <= 8'h00;
      sysov_q     <= 1'b0;
      opt_done_q  <= 1'b0;
      charge_ok_q <= 1'b0;
      hot_n_q     <= 1'b1;
      ch_q        <= 3'h0;
      rdata_q     <= 16'h0000;
      rvalid_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      meas_q      <= meas_d;
      throttle_q  <= throttle_d;
      fault_q     <= fault_d;
      sysov_q     <= sysov_d;
      opt_done_q  <= opt_done_d;
      charge_ok_q <= CHARGE_OK_INDICATION;
      hot_n_q     <= hot_n_d;
      ch_q        <= ch_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= REG_RD;
    end
  end

  // Channels whose enable bit is clear still take their full step, without a result.
  assign CONV_CHANNEL         = ch_q;
  assign CONVERTER_ACTIVE     = (state_q == CAS_CONVERT)
                                && !LOW_POWER_MODE;
  assign CONV_CHANNEL_VALID   = CONVERTER_ACTIVE && meas_q[ch_q];
  assign RESULTS_UPDATE       = CONVERTER_ACTIVE && tmr_done
                                && (ch_q == CH_LAST);
  assign CONVERSION_RANGE_SEL = meas_q[MO_RANGE];
  assign LOW_POWER_EXIT_REQ   = LOW_POWER_MODE && BATTERY_ONLY
                                && (meas_q[MO_MODE] || meas_q[MO_TRIGGER]);
  assign PROCESSOR_HOT_OUTPUT_N = hot_n_q;
  assign POWER_STAGE_ENABLE   = !sysov_q;
  assign REG_RDATA            = rdata_q;
  assign REG_RVALID           = rvalid_q;

endmodule // cas_regs

/* rtl/cas_pkg.sv */
package cas_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CONV_SET_MS      = 10;
  localparam int unsigned CONV_PERIOD_MS   = 1000;
  localparam int unsigned CONV_SET_CYC     = CLK_HZ / 1000 * CONV_SET_MS;
  localparam int unsigned CONV_PERIOD_CYC  = CLK_HZ / 1000 * CONV_PERIOD_MS;

  localparam logic [7:0] ADDR_STATE_FLAGS  = 8'h20;
  localparam logic [7:0] ADDR_THROTTLE     = 8'h34;
  localparam logic [7:0] ADDR_MEAS_OPT     = 8'h35;

  localparam logic [15:0] RST_STATE_FLAGS  = 16'h0000;
  localparam logic [15:0] RST_THROTTLE     = 16'h8120;
  localparam logic [15:0] RST_MEAS_OPT     = 16'h2000;
  localparam logic [15:0] MEAS_OPT_WMASK   = 16'hE0FF;

  localparam int unsigned MO_MODE          = 15;
  localparam int unsigned MO_TRIGGER       = 14;
  localparam int unsigned MO_RANGE         = 13;
  localparam int unsigned TP_ADAPTER_LOSS  = 0;
  localparam int unsigned CO0_ADAPTER_BIT  = 15;

  localparam int unsigned SF_PRESENT       = 15;
  localparam int unsigned SF_OPT_DONE      = 14;
  localparam int unsigned SF_VLIM          = 12;
  localparam int unsigned SF_ILIM          = 11;
  localparam int unsigned SF_FAST          = 10;
  localparam int unsigned SF_PRE           = 9;
  localparam int unsigned SF_REVERSE       = 8;
  localparam int unsigned SF_IN_OV         = 7;
  localparam int unsigned SF_BAT_OC        = 6;
  localparam int unsigned SF_IN_OC         = 5;
  localparam int unsigned SF_SYS_OV        = 4;
  localparam int unsigned SF_LATCHOFF      = 2;
  localparam int unsigned SF_REV_OV        = 1;
  localparam int unsigned SF_REV_OC        = 0;

  localparam int unsigned NUM_CH           = 8;
  localparam logic [2:0]  CH_LAST          = 3'h7;

  typedef enum logic [1:0] {
    CAS_IDLE    = 2'b00,
    CAS_CONVERT = 2'b01,
    CAS_WAIT    = 2'b10
  } cas_conv_state_t;

endpackage : cas_pkg

/* rtl/cas_timer.sv */
`timescale 1ns/1ps

module cas_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             CLEAR,
  input  wire logic [WIDTH-1:0] LIMIT,
  output logic                  DONE
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // Counts up while not cleared; DONE is high on the final count.
  always_comb begin
    if (CLEAR || DONE) begin
      count_d = '0;
    end else begin
      count_d = count_q + WIDTH'(1);
    end
  end

  assign DONE = !CLEAR && (count_q == LIMIT - WIDTH'(1));

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // cas_timer

/* testbench/cas_regs_asserts.sv */
`timescale 1ns/1ps

module cas_regs_asserts
  import cas_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic        CHARGE_OK_INDICATION,
  input wire logic        SYSTEM_OVERVOLTAGE,
  input wire logic        LOW_POWER_MODE,
  input wire logic        PROCESSOR_HOT_OUTPUT_N,
  input wire logic        CONVERTER_ACTIVE,
  input wire logic [2:0]  CONV_CHANNEL,
  input wire logic        CONV_CHANNEL_VALID,
  input wire logic        CONVERSION_RANGE_SEL,
  input wire logic        RESULTS_UPDATE,
  input wire logic        POWER_STAGE_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Each step lasts four cycles with the short count used by the bench.
  sequence s_step_held;
    $stable(CONV_CHANNEL)[*3];
  endsequence
  sequence s_set_closed;
    (CONV_CHANNEL == CH_LAST) ##1 !RESULTS_UPDATE;
  endsequence

  chk_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered next cycle");
  chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  chk_range_follow: assert property (REG_WR && REG_ADDR == ADDR_MEAS_OPT
    |=> CONVERSION_RANGE_SEL == $past(REG_WDATA[13]))
    else $error("range select does not follow write");
  chk_sysov_stage: assert property (SYSTEM_OVERVOLTAGE
    |-> ##[0:2] !POWER_STAGE_ENABLE)
    else $error("power stage still enabled in overvoltage");
  chk_lp_inactive: assert property (LOW_POWER_MODE
    |-> !CONVERTER_ACTIVE)
    else $error("converter active in low power");
  chk_hot_adapter: assert property (CHARGE_OK_INDICATION[*2]
    |=> PROCESSOR_HOT_OUTPUT_N)
    else $error("throttle output low with adapter present");
  chk_step_hold: assert property ($changed(CONV_CHANNEL)
    && CONVERTER_ACTIVE |=> s_step_held)
    else $error("channel step too short");
  chk_chan_order: assert property ($changed(CONV_CHANNEL) &&
    CONVERTER_ACTIVE && CONV_CHANNEL != 3'h0
    |-> CONV_CHANNEL == $past(CONV_CHANNEL) + 3'h1)
    else $error("channel order broken");
  chk_valid_gate: assert property (CONV_CHANNEL_VALID
    |-> CONVERTER_ACTIVE)
    else $error("channel valid while converter idle");
  chk_update_last: assert property (RESULTS_UPDATE |-> s_set_closed)
    else $error("results update not at end of set");
endmodule // cas_regs_asserts

bind cas_regs cas_regs_asserts u_asserts (.*);

/* testbench/cas_host_model.sv */
`timescale 1ns/1ps

module cas_host_model (
  input  wire logic        CLK,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_RVALID,
  output logic             REG_WR    = 1'b0,
  output logic             REG_RD    = 1'b0,
  output logic [7:0]       REG_ADDR  = 8'h00,
  output logic [15:0]      REG_WDATA = 16'h0000
);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
  endtask

  // Returns the valid flag above the read word.
  task automatic rd(input logic [7:0] a, output logic [16:0] r);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(posedge CLK);
    #1;
    REG_RD = 1'b0;
    r      = {REG_RVALID, REG_RDATA};
  endtask
endmodule // cas_host_model

/* testbench/charger_adc_status_regs_tb.sv */
`timescale 1ns/1ps

module charger_adc_status_regs_tb;
  import cas_pkg::*;
  localparam int S = 32;
  localparam int P = 64;
  logic CLK, RESET_N, SYSTEM_OVERVOLTAGE, LOW_POWER_MODE, BATTERY_ONLY;
  logic [15:0] CHARGE_OPTION_WORD0, REG_RDATA, REG_WDATA, wd;
  logic [7:0] REG_ADDR;
  logic [6:0] lv;
  logic [5:0] fv;
  logic [16:0] r;
  wire REG_WR, REG_RD;
  wire CHARGE_OK_INDICATION, INPUT_OPTIMIZER_FINISHED, PRECHARGE;
  wire INPUT_VOLTAGE_LIMITING, INPUT_CURRENT_LIMITING, FAST_CHARGE;
  wire REVERSE_OUTPUT, INPUT_OVERVOLTAGE_FAULT, BATTERY_OVERCURRENT_FAULT;
  wire INPUT_OVERCURRENT_FAULT, LATCHOFF_FAULT, REVERSE_OVERVOLTAGE_FAULT;
  wire REVERSE_OVERCURRENT_FAULT;
  logic REG_RVALID, LOW_POWER_EXIT_REQ, PROCESSOR_HOT_OUTPUT_N;
  logic CONVERTER_ACTIVE, CONV_CHANNEL_VALID, CONVERSION_RANGE_SEL;
  logic RESULTS_UPDATE, POWER_STAGE_ENABLE;
  logic [2:0] CONV_CHANNEL;
  int n_fail, n_tests, np, nv, gap, last;

  assign {CHARGE_OK_INDICATION, INPUT_OPTIMIZER_FINISHED,
    INPUT_VOLTAGE_LIMITING, INPUT_CURRENT_LIMITING, FAST_CHARGE,
    PRECHARGE, REVERSE_OUTPUT} = lv;
  assign {INPUT_OVERVOLTAGE_FAULT, BATTERY_OVERCURRENT_FAULT,
    INPUT_OVERCURRENT_FAULT, LATCHOFF_FAULT, REVERSE_OVERVOLTAGE_FAULT,
    REVERSE_OVERCURRENT_FAULT} = fv;

  cas_regs #(.SET_CYC(S), .PERIOD_CYC(P)) DUT (.*);
  cas_host_model HOST (.*);

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  function automatic logic [16:0] st(logic [6:0] l, logic [5:0] f,
                                     logic s);
    return {1'b1, l[6], l[5] & l[6], 1'b0, l[4:0], f[5:3], s, 1'b0,
            f[2:0]};
  endfunction

  task chk(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // Counts end-of-set pulses and the spacing between the last two.
  task watch(input int cyc);
    np = 0;
    nv = 0;
    repeat (cyc) begin
      step(1);
      if (CONV_CHANNEL_VALID === 1'b1)
        nv++;
      if (RESULTS_UPDATE === 1'b1) begin
        np++;
        gap  = $time / 10 - last;
        last = $time / 10;
      end
    end
  endtask

  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #900_000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    {RESET_N, lv, fv, SYSTEM_OVERVOLTAGE, LOW_POWER_MODE} = '0;
    {BATTERY_ONLY, CHARGE_OPTION_WORD0} = '0;
    void'($urandom(77));
    step(10);
    RESET_N = 1'b1;
    HOST.rd(ADDR_MEAS_OPT, r);
    chk(r, 17'h12000);
    HOST.rd(ADDR_THROTTLE, r);
    chk(r, 17'h18120);
    HOST.rd(ADDR_STATE_FLAGS, r);
    chk(r, st(lv, 6'h00, 1'b0));
    HOST.rd(8'h21, r);
    chk(r, 17'h10000);
    repeat (6) begin
      wd        = 16'($urandom) & 16'h3FFF;
      HOST.wr(ADDR_MEAS_OPT, wd);
      HOST.rd(ADDR_MEAS_OPT, r);
      chk(r, {1'b1, wd & MEAS_OPT_WMASK});
      chk(CONVERSION_RANGE_SEL, wd[13]);
    end
    repeat (8) begin
      lv = 7'($urandom);
      step(2);
      HOST.rd(ADDR_STATE_FLAGS, r);
      chk(r, st(lv, 6'h00, 1'b0));
    end
    for (int i = 0; i < 6; i++) begin
      fv = 6'h01 << i;
      step(1);
      fv = 6'h00;
      HOST.rd(ADDR_STATE_FLAGS, r);
      chk(r, st(lv, 6'h01 << i, 1'b0));
      HOST.rd(ADDR_STATE_FLAGS, r);
      chk(r, st(lv, 6'h00, 1'b0));
    end
    fv = 6'h3F;
    HOST.rd(ADDR_STATE_FLAGS, r);
    HOST.rd(ADDR_STATE_FLAGS, r);
    chk(r, st(lv, 6'h3F, 1'b0));
    fv = 6'h00;
    lv = 7'h40;
    SYSTEM_OVERVOLTAGE = 1'b1;
    step(3);
    SYSTEM_OVERVOLTAGE = 1'b0;
    HOST.wr(ADDR_STATE_FLAGS, 16'hFFFF);
    HOST.rd(ADDR_STATE_FLAGS, r);
    chk(r, st(lv, 6'h3F, 1'b1));
    chk(POWER_STAGE_ENABLE, 1'b0);
    HOST.wr(ADDR_STATE_FLAGS, 16'h0000);
    step(1);
    chk(POWER_STAGE_ENABLE, 1'b1);
    HOST.wr(ADDR_THROTTLE, 16'h8121);
    lv = 7'h00;
    step(3);
    chk(PROCESSOR_HOT_OUTPUT_N, 1'b0);
    CHARGE_OPTION_WORD0 = 16'h8000;
    step(3);
    chk(PROCESSOR_HOT_OUTPUT_N, 1'b1);
    HOST.wr(ADDR_MEAS_OPT, 16'h4055);
    last = $time / 10;
    watch(S + 40);
    chk(np, 1);
    chk(nv, S / 2);
    chk(gap >= S && gap <= S + 3, 1'b1);
    HOST.rd(ADDR_MEAS_OPT, r);
    chk(r, 17'h10055);
    HOST.wr(ADDR_MEAS_OPT, 16'h80FF);
    watch(3 * P + 40);
    chk(np >= 3, 1'b1);
    chk(gap, P);
    {LOW_POWER_MODE, BATTERY_ONLY} = 2'b11;
    HOST.wr(ADDR_MEAS_OPT, 16'h40FF);
    chk(LOW_POWER_EXIT_REQ, 1'b1);
    BATTERY_ONLY = 1'b0;
    watch(S + 8);
    chk(CONVERTER_ACTIVE, 1'b0);
    chk(np, 0);
    chk(LOW_POWER_EXIT_REQ, 1'b0);
    report_and_stop();
  end
endmodule // charger_adc_status_regs_tb
